// ### tmc_tape_ctrl.sv
/*
  tmc_tape_ctrl: microcassette mechanism and block sequencing control,
  APB register slave, pin synchronisers and a one-block byte buffer.
  Assumes a motor/head driver board on the mechanism pins and a same-clock
  byte serializer/deserializer on the tape byte streams.
*/
// Notes on behaviour
// - tape moves whole 256-byte blocks only
// - volume opens with three directory blocks
// - file is header, data blocks, end block
// - capstan code, erase, head load per operation
// - speed regulation off in fast modes
// - reel count pulses tracked, four per turn
// - pinch control high turns the cams
// - head position read from cam switch
// - erase low-active, only while writing
// - sample write-enable tab sense
// - mechanism powered only while in use
`timescale 1ns/10ps
module tmc_tape_ctrl
  import tmc_pkg::*;
#(
  parameter int SETTLE_CYC = tmc_pkg::POWER_SETTLE_CYC,
  parameter int BRAKE_LEN  = tmc_pkg::BRAKE_CYC
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              headPositionSwitch,
  input  wire logic              writeEnableSense,
  input  wire logic              reelCountInput,
  input  wire logic              tapeReadData,
  output tmc_pkg::tmc_mech_t     mechOut,
  output tmc_pkg::tmc_byte_t     wrByte,
  output logic                   wrValid,
  input  wire logic              wrReady,
  input  wire logic [7:0]        rdByte,
  input  wire logic              rdValid,
  output logic                   rdReady
);
  import tmc_pkg::*;

  // ==========================================================
  // declarations
  localparam int NPIN = 4;
  logic [NPIN-1:0] pinIn;
  logic [NPIN-1:0] syncA_ff, syncB_ff, syncC_ff, pinLvl_ff;
  logic            headLoaded, weOk, reelLvl, reelPrev_ff;
  tmc_state_t      state_ff, nxt_state;
  tmc_op_t         op_ff;
  logic [31:0]     cnt_ff;
  logic [31:0]     pos_ff;
  logic [15:0]     blkCnt_ff;
  logic [1:0]      dirCnt_ff;
  tmc_file_t       fileSt_ff;
  logic            blkAct_ff, fetch_ff, done_ff, seqErr_ff, protErr_ff;
  tmc_kind_t       blkKind_ff;
  logic [PTR_W-1:0] blkPtr_ff, bufPtr_ff;
  logic [PTR_W:0]  fill_ff;
  logic            ack_ff;
  logic [31:0]     rdMux;
  logic [7:0]      ramRd;
  logic            access, wrAcc, mapped;
  logic            ctrlWr, statWr, posWr, blkWr, dataWr, dataRd, ptrWr;
  logic            startReq, stopReq, opValid, goReq, goOk;
  logic            wrXfer, rdXfer, lastByte, ramWe;
  logic [PTR_W-1:0] ramWa, ramRa;
  logic [7:0]      ramWd;
  tmc_op_t         reqOp;
  tmc_kind_t       reqKind;

  // ==========================================================
  // helper functions
  function automatic logic needLoad(input tmc_op_t op);
    needLoad = (op == OP_READ) || (op == OP_WRITE);
  endfunction

  // order checker for directory and file structure
  function automatic logic kindLegal(input tmc_kind_t k,
                                     input logic [1:0] dc,
                                     input tmc_file_t fs);
    if (dc < 2'(DIR_BLOCKS))
    begin
      kindLegal = (k == BK_DIR);
    end
    else
    begin
      case (k)
        BK_HDR:  kindLegal = (fs == FS_NONE);
        BK_DATA: kindLegal = (fs != FS_NONE);
        BK_EOF:  kindLegal = (fs == FS_DATA);
        default: kindLegal = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // pin synchronisers, change taken when stages two and three agree
  assign pinIn = {tapeReadData, reelCountInput, writeEnableSense,
                  headPositionSwitch};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          syncA_ff[gi]  <= 1'b0;
          syncB_ff[gi]  <= 1'b0;
          syncC_ff[gi]  <= 1'b0;
          pinLvl_ff[gi] <= 1'b0;
        end
        else
        begin
          syncA_ff[gi] <= pinIn[gi];
          syncB_ff[gi] <= syncA_ff[gi];
          syncC_ff[gi] <= syncB_ff[gi];
          if (syncB_ff[gi] == syncC_ff[gi])
          begin
            pinLvl_ff[gi] <= syncC_ff[gi];
          end
        end
      end
    end
  endgenerate

  assign headLoaded = pinLvl_ff[0];
  assign weOk       = pinLvl_ff[1];
  assign reelLvl    = pinLvl_ff[2];

  // ==========================================================
  // apb decode, one wait state on every transfer
  assign access = psel & penable;
  assign pready = access & ack_ff;
  assign wrAcc  = pready & pwrite;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) ||
                  (paddr == OFF_POS) || (paddr == OFF_BLOCK) ||
                  (paddr == OFF_DATA) || (paddr == OFF_PTR);
  // data port is refused while the tape owns the buffer
  assign pslverr = pready & (~mapped | ((paddr == OFF_DATA) & blkAct_ff));
  assign ctrlWr = wrAcc & (paddr == OFF_CTRL);
  assign statWr = wrAcc & (paddr == OFF_STATUS);
  assign posWr  = wrAcc & (paddr == OFF_POS);
  assign blkWr  = wrAcc & (paddr == OFF_BLOCK);
  assign ptrWr  = wrAcc & (paddr == OFF_PTR);
  assign dataWr = wrAcc & (paddr == OFF_DATA) & ~blkAct_ff;
  assign dataRd = pready & ~pwrite & (paddr == OFF_DATA) & ~blkAct_ff;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= access & ~ack_ff;
    end
  end

  // read data mux, captured in the first access cycle
  always_comb
  begin
    rdMux = 32'h0000_0000;
    case (paddr)
      OFF_CTRL:   rdMux = {29'h0, op_ff};
      OFF_STATUS:
      begin
        rdMux[ST_LOADED_BIT]  = headLoaded;
        rdMux[ST_WE_BIT]      = weOk;
        rdMux[ST_BUSY_BIT]    = (state_ff != S_IDLE);
        rdMux[ST_RUN_BIT]     = (state_ff == S_RUN);
        rdMux[ST_BLKACT_BIT]  = blkAct_ff;
        rdMux[ST_RDDATA_BIT]  = pinLvl_ff[3];
        rdMux[ST_DONE_BIT]    = done_ff;
        rdMux[ST_SEQERR_BIT]  = seqErr_ff;
        rdMux[ST_PROTERR_BIT] = protErr_ff;
      end
      OFF_POS:    rdMux = pos_ff;
      OFF_BLOCK:  rdMux = {16'h0, blkCnt_ff};
      OFF_DATA:   rdMux = {24'h0, ramRd};
      OFF_PTR:    rdMux = {23'h0, fill_ff};
      default:    rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (access & ~ack_ff & ~pwrite)
    begin
      prdata <= rdMux;
    end
  end

  // ==========================================================
  // mechanism sequencer
  assign reqOp    = tmc_op_t'(pwdata[CTRL_OP_LSB +: 3]);
  assign opValid  = (pwdata[CTRL_OP_LSB +: 3] <= 3'h5);
  assign startReq = ctrlWr & pwdata[CTRL_START_BIT] & opValid &
                    (state_ff == S_IDLE) &
                    ~((reqOp == OP_WRITE) & ~weOk);
  assign stopReq  = ctrlWr & pwdata[CTRL_STOP_BIT];

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:  if (startReq) nxt_state = S_POWER;
      S_POWER: if (cnt_ff >= 32'(SETTLE_CYC - 1)) nxt_state = S_HEAD;
      S_HEAD:
      begin
        if (stopReq)
          nxt_state = S_BRAKE;
        else if (headLoaded == needLoad(op_ff))
          nxt_state = S_RUN;
      end
      S_RUN:
      begin
        if (stopReq | ((op_ff == OP_WRITE) & ~weOk))
          nxt_state = S_BRAKE;
      end
      S_BRAKE: if (cnt_ff >= 32'(BRAKE_LEN - 1)) nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= S_IDLE;
      op_ff    <= OP_READ;
      cnt_ff   <= 32'h0000_0000;
    end
    else
    begin
      state_ff <= nxt_state;
      if (startReq)
        op_ff <= reqOp;
      if (nxt_state != state_ff)
        cnt_ff <= 32'h0000_0000;
      else
        cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end

  // mechanism pins, registered
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mechOut <= '{default: 1'b0, eraseControlN: 1'b1};
    end
    else
    begin
      mechOut.mechanismPowerControl <= (state_ff != S_IDLE);
      mechOut.pinchMotorControl <= (state_ff == S_HEAD) &
                                   (headLoaded != needLoad(op_ff));
      mechOut.eraseControlN <= ~((state_ff == S_RUN) &
                               (op_ff == OP_WRITE) & weOk);
      mechOut.speedControlEnable <= (state_ff == S_RUN) &
                             (op_ff != OP_FFWD) & (op_ff != OP_FREW);
      if (state_ff == S_RUN)
      begin
        case (op_ff)
          OP_FFWD: {mechOut.capstanLineC, mechOut.capstanLineB,
                    mechOut.capstanLineA} <= CAP_FFWD;
          OP_FREW: {mechOut.capstanLineC, mechOut.capstanLineB,
                    mechOut.capstanLineA} <= CAP_FREW;
          OP_SREW: {mechOut.capstanLineC, mechOut.capstanLineB,
                    mechOut.capstanLineA} <= CAP_SREW;
          default: {mechOut.capstanLineC, mechOut.capstanLineB,
                    mechOut.capstanLineA} <= CAP_FWD;
        endcase
      end
      else if (state_ff == S_BRAKE)
        {mechOut.capstanLineC, mechOut.capstanLineB,
         mechOut.capstanLineA} <= CAP_BRAKE;
      else
        {mechOut.capstanLineC, mechOut.capstanLineB,
         mechOut.capstanLineA} <= CAP_FLOAT;
    end
  end

  // ==========================================================
  // reel position, up when winding forward, down when rewinding
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reelPrev_ff <= 1'b0;
      pos_ff      <= POS_RST;
    end
    else
    begin
      reelPrev_ff <= reelLvl;
      if (posWr)
        pos_ff <= pwdata;
      else if (reelLvl & ~reelPrev_ff)
      begin
        if ((op_ff == OP_FREW) | (op_ff == OP_SREW))
          pos_ff <= pos_ff - 32'h0000_0001;
        else
          pos_ff <= pos_ff + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // block engine
  assign reqKind  = tmc_kind_t'(pwdata[BLK_KIND_LSB +: 2]);
  assign goReq    = blkWr & pwdata[BLK_GO_BIT];
  assign goOk = goReq & ~blkAct_ff & (state_ff == S_RUN) &
                needLoad(op_ff) & kindLegal(reqKind, dirCnt_ff, fileSt_ff) &
                ((op_ff != OP_WRITE) |
                 (fill_ff == (PTR_W+1)'(BLOCK_BYTES)));
  assign wrXfer   = wrValid & wrReady;
  assign rdXfer   = rdReady & rdValid;
  assign lastByte = (blkPtr_ff == PTR_W'(BLOCK_BYTES - 1));

  assign wrValid = blkAct_ff & (op_ff == OP_WRITE) & ~fetch_ff;
  assign rdReady = blkAct_ff & (op_ff == OP_READ);
  assign wrByte  = '{kind: blkKind_ff, first: (blkPtr_ff == '0),
                     data: ramRd};

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      blkAct_ff  <= 1'b0;
      fetch_ff   <= 1'b0;
      blkPtr_ff  <= '0;
      blkKind_ff <= BK_DIR;
      blkCnt_ff  <= BCNT_RST;
      dirCnt_ff  <= 2'h0;
      fileSt_ff  <= FS_NONE;
    end
    else
    begin
      fetch_ff <= 1'b0;
      if (goOk)
      begin
        blkAct_ff  <= 1'b1;
        fetch_ff   <= 1'b1;
        blkPtr_ff  <= '0;
        blkKind_ff <= reqKind;
      end
      else if (blkAct_ff & (wrXfer | rdXfer))
      begin
        blkPtr_ff <= blkPtr_ff + PTR_W'(1);
        fetch_ff  <= 1'b1;
        if (lastByte)
        begin
          blkAct_ff <= 1'b0;
          blkCnt_ff <= blkCnt_ff + 16'h0001;
          case (blkKind_ff)
            BK_DIR:  dirCnt_ff <= dirCnt_ff + 2'h1;
            BK_HDR:  fileSt_ff <= FS_HDR;
            BK_DATA: fileSt_ff <= FS_DATA;
            default: fileSt_ff <= FS_NONE;
          endcase
        end
      end
      else if (blkAct_ff & (state_ff != S_RUN))
        blkAct_ff <= 1'b0; // abandoned when the tape stops
      if (ctrlWr & pwdata[CTRL_NEWVOL_BIT] & ~blkAct_ff)
      begin
        dirCnt_ff <= 2'h0;
        fileSt_ff <= FS_NONE;
        blkCnt_ff <= BCNT_RST;
      end
    end
  end

  // sticky flags, a set in the clearing cycle wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      done_ff    <= 1'b0;
      seqErr_ff  <= 1'b0;
      protErr_ff <= 1'b0;
    end
    else
    begin
      done_ff <= (blkAct_ff & (wrXfer | rdXfer) & lastByte) |
                 (done_ff & ~(statWr & pwdata[ST_DONE_BIT]));
      seqErr_ff <= (goReq & ~goOk) |
                   (seqErr_ff & ~(statWr & pwdata[ST_SEQERR_BIT]));
      protErr_ff <= (ctrlWr & pwdata[CTRL_START_BIT] &
                     (reqOp == OP_WRITE) & ~weOk) |
                    ((state_ff == S_RUN) & (op_ff == OP_WRITE) & ~weOk) |
                    (protErr_ff & ~(statWr & pwdata[ST_PROTERR_BIT]));
    end
  end

  // software buffer pointer and fill count
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bufPtr_ff <= '0;
      fill_ff   <= '0;
    end
    else
    begin
      if (ptrWr | goOk)
      begin
        bufPtr_ff <= '0;
        fill_ff   <= '0;
      end
      else if (dataWr | dataRd)
      begin
        bufPtr_ff <= bufPtr_ff + PTR_W'(1);
        if (dataWr && fill_ff != (PTR_W+1)'(BLOCK_BYTES))
          fill_ff <= fill_ff + (PTR_W+1)'(1);
      end
    end
  end

  // ==========================================================
  // block buffer
  assign ramWe = (blkAct_ff & rdXfer) | dataWr;
  assign ramWa = blkAct_ff ? blkPtr_ff : bufPtr_ff;
  assign ramWd = blkAct_ff ? rdByte : pwdata[7:0];
  assign ramRa = blkAct_ff ? blkPtr_ff : bufPtr_ff;

  tmc_block_ram #(
    .DEPTH (BLOCK_BYTES),
    .AW    (PTR_W)
  ) u_ram (
    .clock  (clock),
    .rst    (rst),
    .wrEn   (ramWe),
    .wrAddr (ramWa),
    .wrData (ramWd),
    .rdAddr (ramRa),
    .rdData (ramRd)
  );
endmodule // tmc_tape_ctrl

// ### tmc_pkg.sv
/*
  tmc_pkg: constants, state and mode codes and carrier types shared by
  the tape mechanism controller, its monitor, mechanism model and bench.
  Assumes a 100 MHz system clock and 32-bit APB register access.
*/
package tmc_pkg;

  // ==========================================================
  // clock and times
  localparam int CLK_MHZ          = 100;
  localparam int POWER_SETTLE_US  = 10000; // supply settle after power on
  localparam int BRAKE_US         = 20000; // capstan brake before power off
  localparam int POWER_SETTLE_CYC = POWER_SETTLE_US * CLK_MHZ;
  localparam int BRAKE_CYC        = BRAKE_US * CLK_MHZ;

  // ==========================================================
  // block format
  localparam int BLOCK_BYTES = 256;
  localparam int PTR_W       = 8;
  localparam int DIR_BLOCKS  = 3;
  localparam int COUNTS_PER_REV = 4;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_POS    = 8'h08;
  localparam logic [7:0] OFF_BLOCK  = 8'h0c;
  localparam logic [7:0] OFF_DATA   = 8'h10;
  localparam logic [7:0] OFF_PTR    = 8'h14;

  // control fields
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_START_BIT = 3;
  localparam int CTRL_STOP_BIT  = 4;
  localparam int CTRL_NEWVOL_BIT = 5;
  // block command fields
  localparam int BLK_KIND_LSB = 0;
  localparam int BLK_GO_BIT   = 2;
  // status fields
  localparam int ST_LOADED_BIT  = 0;
  localparam int ST_WE_BIT      = 1;
  localparam int ST_BUSY_BIT    = 2;
  localparam int ST_RUN_BIT     = 3;
  localparam int ST_BLKACT_BIT  = 4;
  localparam int ST_RDDATA_BIT  = 5;
  localparam int ST_DONE_BIT    = 8;
  localparam int ST_SEQERR_BIT  = 9;
  localparam int ST_PROTERR_BIT = 10;

  // reset values
  localparam logic [31:0] POS_RST  = 32'h0000_0000;
  localparam logic [15:0] BCNT_RST = 16'h0000;

  // ==========================================================
  // operations and capstan codes {c,b,a}
  typedef enum logic [2:0] {
    OP_READ  = 3'h0,
    OP_WRITE = 3'h1,
    OP_FFWD  = 3'h2,
    OP_FREW  = 3'h3,
    OP_SFWD  = 3'h4,
    OP_SREW  = 3'h5
  } tmc_op_t;

  localparam logic [2:0] CAP_FWD   = 3'h1;
  localparam logic [2:0] CAP_FFWD  = 3'h5;
  localparam logic [2:0] CAP_FREW  = 3'h6;
  localparam logic [2:0] CAP_SREW  = 3'h2;
  localparam logic [2:0] CAP_BRAKE = 3'h3;
  localparam logic [2:0] CAP_FLOAT = 3'h0;

  typedef enum logic [1:0] {
    BK_DIR  = 2'h0,
    BK_HDR  = 2'h1,
    BK_DATA = 2'h2,
    BK_EOF  = 2'h3
  } tmc_kind_t;

  typedef enum logic [1:0] {
    FS_NONE = 2'h0,
    FS_HDR  = 2'h1,
    FS_DATA = 2'h2
  } tmc_file_t;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_POWER = 5'h02,
    S_HEAD  = 5'h04,
    S_RUN   = 5'h08,
    S_BRAKE = 5'h10
  } tmc_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic capstanLineC;
    logic capstanLineB;
    logic capstanLineA;
    logic pinchMotorControl;
    logic eraseControlN;
    logic mechanismPowerControl;
    logic speedControlEnable;
  } tmc_mech_t;

  typedef struct packed {
    tmc_kind_t  kind;
    logic       first;
    logic [7:0] data;
  } tmc_byte_t;

endpackage

// ### tmc_block_ram.sv
/*
  tmc_block_ram: one tape block of byte storage, one write port and one
  read port, read data registered.
  Assumes a single clock; no reset on the array itself.
*/
`timescale 1ns/10ps
module tmc_block_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [7:0]    wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [7:0]    rdData
);
  logic [7:0] memArr [DEPTH];

  // ==========================================================
  // storage write
  always_ff @(posedge clock)
  begin
    if (wrEn)
    begin
      memArr[wrAddr] <= wrData;
    end
  end

  // registered read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rdData <= 8'h00;
    end
    else
    begin
      rdData <= memArr[rdAddr];
    end
  end
endmodule // tmc_block_ram

// ### tmc_monitor.sv
/*
  tmc_monitor: port assertions for tmc_tape_ctrl.
  Assumes one clock, rst async high; bound to every instance.
*/
`timescale 1ns/10ps
module tmc_monitor
  import tmc_pkg::*;
(
  input logic               clock,
  input logic               rst,
  input logic               psel,
  input logic               penable,
  input logic               pready,
  input logic               pslverr,
  input logic               headPositionSwitch,
  input tmc_pkg::tmc_mech_t mechOut,
  input logic               wrValid,
  input logic               wrReady
);
  logic [2:0] cap;
  logic       pin, ers, pwr, spd;

  // unpack mechanism levels
  assign {cap, pin, ers, pwr, spd} = mechOut;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // ==========================================================
  // mechanism levels
  code_legal_a: assert property (
    cap != 3'h4 && cap != 3'h7) else $error("bad capstan code");
  unpowered_idle_a: assert property (
    !pwr |-> cap == 3'h0 && !pin && ers && !spd)
    else $error("unpowered drive");
  erase_write_a: assert property (
    !ers |-> cap == 3'h1 && !pin && spd && pwr)
    else $error("erase outside write");
  erase_head_a: assert property (
    !ers |-> headPositionSwitch) else $error("erase unloaded");
  speed_mode_a: assert property (
    spd |-> cap == 3'h1 || cap == 3'h2) else $error("speed ctl in fast");
  pinch_still_a: assert property (
    pin |-> cap == 3'h0 && ers) else $error("pinch with capstan");
  brake_off_a: assert property (
    $fell(pwr) |-> $past(cap) == 3'h3) else $error("no brake at off");

  // ==========================================================
  // bus and byte stream
  apb_wait_a: assert property (
    $rose(penable) && psel |-> !pready ##1 pready) else $error("apb wait");
  err_ready_a: assert property (
    pslverr |-> pready) else $error("lone pslverr");
  byte_gap_a: assert property (
    wrValid && wrReady |=> !wrValid) else $error("byte too soon");
endmodule // tmc_monitor

bind tmc_tape_ctrl tmc_monitor tmc_monitor_i (.clock, .rst, .psel,
  .penable, .pready, .pslverr, .headPositionSwitch, .mechOut,
  .wrValid, .wrReady);

// ### tmc_mech_model.sv
/*
  tmc_mech_model: tape mechanism and driver board model.
  Assumes mechOut of tmc_tape_ctrl, write tab from bench.
*/
`timescale 1ns/10ps
module tmc_mech_model
  import tmc_pkg::*;
#(
  parameter int CAM_CYC  = 20,
  parameter int SLOW_CYC = 6,
  parameter int FAST_CYC = 3
) (
  input  logic               clock,
  input  logic               rst,
  input  tmc_pkg::tmc_mech_t mechOut,
  input  logic               writeTab,
  output logic               headPositionSwitch,
  output logic               writeEnableSense,
  output logic               reelCountInput,
  output logic               tapeReadData,
  output int                 pulseCount
);
  int   camCnt_ff;
  int   reelCnt_ff;
  logic moving;

  // exactly one of capstan lines A and B high moves the tape
  assign moving = mechOut.mechanismPowerControl &
                  (mechOut.capstanLineA ^ mechOut.capstanLineB);
  assign writeEnableSense = writeTab;

  // cam turns while pinch driven
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      camCnt_ff <= 0;
      headPositionSwitch <= 1'b0;
    end
    else if (mechOut.pinchMotorControl &
             mechOut.mechanismPowerControl)
    begin
      camCnt_ff <= (camCnt_ff == CAM_CYC - 1) ? 0 : camCnt_ff + 1;
      if (camCnt_ff == CAM_CYC - 1)
        headPositionSwitch <= ~headPositionSwitch;
    end
  end

  // reel pulses, slower when regulated
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reelCnt_ff <= 0;
      reelCountInput <= 1'b0;
      pulseCount <= 0;
    end
    else if (moving)
    begin
      if (reelCnt_ff >=
          (mechOut.speedControlEnable ? SLOW_CYC : FAST_CYC))
      begin
        reelCnt_ff <= 0;
        reelCountInput <= ~reelCountInput;
        if (!reelCountInput)
          pulseCount <= pulseCount + 1;
      end
      else
        reelCnt_ff <= reelCnt_ff + 1;
    end
  end

  // read line toggles
  always_ff @(posedge clock)
    tapeReadData <= ~tapeReadData | rst;
endmodule // tmc_mech_model

// ### test_tmc_tape_ctrl.sv
/*
  test_tmc_tape_ctrl: self-checking bench.
  Assumes tmc_mech_model on pins, tmc_monitor bound.
*/
`timescale 1ns/10ps
module test_tmc_tape_ctrl;
  import tmc_pkg::*;
  localparam logic [2:0] CAP_EXP [6] = '{3'h1, 3'h1, 3'h5, 3'h6, 3'h1, 3'h2};
  localparam logic [5:0] SPD_EXP = 6'h33;
  localparam logic [5:0] LOAD_EXP = 6'h03;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err, wrValid, rdReady;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic head_position_switch, wes, reel, rdd, wrReady = 1'b0, writeTab = 1'b1;
  tmc_mech_t mech;
  tmc_byte_t wrByte;
  int pulseCount, sentBytes = 0, miscompares = 0, cmp_count = 0, cycles = 0;

  tmc_tape_ctrl #(.SETTLE_CYC(8), .BRAKE_LEN(8)) tmc_tape_ctrl_i (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .headPositionSwitch(head_position_switch), .writeEnableSense(wes),
    .reelCountInput(reel), .tapeReadData(rdd), .mechOut(mech), .wrByte,
    .wrValid, .wrReady, .rdByte(8'h00), .rdValid(1'b0), .rdReady);
  tmc_mech_model tmc_mech_model_i (.clock, .rst, .mechOut(mech), .writeTab,
    .headPositionSwitch(head_position_switch), .writeEnableSense(wes),
    .reelCountInput(reel), .tapeReadData(rdd), .pulseCount);

  // ==========================================================
  // clock, timeout, checks, bus
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 40000)
    begin
      miscompares++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e,
                          input string s);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic chk_mech(input tmc_mech_t g, input tmc_mech_t e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %0t mech got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock iff pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_st(input int b, input logic v);
    int n = 0;
    do
    begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    while (rd[b] !== v && n < 300);
    chk_word(rd[b], v, "wait");
  endtask

  // byte sink, stalls every other cycle
  always @(posedge clock)
  begin
    wrReady <= ~wrReady;
    if (wrValid === 1'b1 && wrReady === 1'b1)
    begin
      chk_word(wrByte.first, sentBytes == 0, "first");
      chk_word(wrByte.data, sentBytes[7:0], "byte");
      sentBytes++;
    end
  end

  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk_mech(mech, 7'h04);
    apb(1'b0, OFF_POS, 32'h0);
    chk_word(rd, POS_RST, "pos reset");
    apb(1'b0, 8'h18, 32'h0);
    chk_word({rd[30:0], err}, 32'h1, "unmapped");
  endtask
  task automatic t_ops;
    int p0;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, OFF_POS, 32'h0);
      p0 = pulseCount;
      apb(1'b1, OFF_CTRL, 32'h8 | 32'(i));
      wait_st(ST_RUN_BIT, 1'b1);
      repeat (40) @(posedge clock);
      chk_mech(mech, {CAP_EXP[i], 1'b0, i != 1, 1'b1,
                      SPD_EXP[i]});
      chk_word(head_position_switch, LOAD_EXP[i], "head");
      apb(1'b1, OFF_CTRL, 32'h10);
      wait_st(ST_BUSY_BIT, 1'b0);
      chk_mech(mech, 7'h04);
      apb(1'b0, OFF_POS, 32'h0);
      chk_word(rd, (i == 3 || i == 5) ? 32'(p0 - pulseCount)
                                      : 32'(pulseCount - p0), "pos");
    end
  endtask
  task automatic t_protect;
    writeTab <= 1'b0;
    repeat (8) @(posedge clock);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_word(rd[ST_WE_BIT], 1'b0, "tab");
    apb(1'b1, OFF_CTRL, 32'h9);
    repeat (20) @(posedge clock);
    chk_mech(mech, 7'h04);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_word(rd[ST_PROTERR_BIT], 1'b1, "prot");
    apb(1'b1, OFF_STATUS, 32'h400);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_word(rd[ST_PROTERR_BIT], 1'b0, "w1c");
    writeTab <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
  task automatic fill;
    apb(1'b1, OFF_PTR, 32'h0);
    for (int i = 0; i < 256; i++)
      apb(1'b1, OFF_DATA, 32'(i));
    apb(1'b0, OFF_PTR, 32'h0);
    chk_word(rd, 32'h100, "fill");
  endtask
  task automatic t_blocks;
    logic [1:0] kinds [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h2};
    apb(1'b1, OFF_CTRL, 32'h20);
    apb(1'b1, OFF_CTRL, 32'h9);
    wait_st(ST_RUN_BIT, 1'b1);
    fill;
    apb(1'b1, OFF_BLOCK, 32'h5);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_word(rd[ST_SEQERR_BIT], 1'b1, "dir first");
    apb(1'b1, OFF_STATUS, 32'h200);
    for (int k = 0; k < 8; k++)
    begin
      fill;
      sentBytes = 0;
      apb(1'b1, OFF_BLOCK, 32'h4 | 32'(kinds[k]));
      if (k == 7)
      begin
        repeat (20) @(posedge clock);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk_word(rd[ST_SEQERR_BIT], 1'b1, "eof order");
        chk_word(sentBytes, 32'h0, "refused");
      end
      else
      begin
        apb(1'b1, OFF_DATA, 32'h0);
        chk_word(err, 1'b1, "busy data");
        chk_word(rdReady, 1'b0, "rdready");
        wait_st(ST_DONE_BIT, 1'b1);
        chk_word(sentBytes, 32'h100, "bytes");
        apb(1'b1, OFF_STATUS, 32'h100);
      end
    end
    apb(1'b0, OFF_BLOCK, 32'h0);
    chk_word(rd, 32'h7, "blocks");
    apb(1'b1, OFF_CTRL, 32'h10);
    wait_st(ST_BUSY_BIT, 1'b0);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_ops;
    t_protect;
    t_blocks;
    give_verdict;
  end
endmodule // test_tmc_tape_ctrl
